// ==== rtl/csc_channel.sv ====
// device end of the cyclic stream channel: sync of both directions, header
// parsing of received sequences and segmenting of messages to be sent
// assumes cyc_en pulses once per bus exchange, after new cyclic bytes arrived
`timescale 1ns/1ns
`include "csc_defines.svh"
module csc_channel (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cyc_en,
   input wire logic [7:0] ctrl_handshake_byte,
   input wire csc_pkg::csc_txwin_t tx_window_bytes,
   output logic [7:0] module_handshake_byte,
   output csc_pkg::csc_rxwin_t rx_window_bytes,
   output logic [7:0] user_rx_data,
   output logic user_rx_valid,
   output logic user_rx_last,
   output logic user_rx_drop,
   input wire logic [7:0] user_tx_data,
   input wire logic user_tx_valid,
   input wire logic user_tx_last,
   output logic user_tx_ready,
   output logic out_synced,
   output logic in_synced
);
   csc_pkg::csc_state_s st;
   csc_pkg::csc_state_s next_st;

   // three-bit counter stepped by one, wrapping modulo eight
   function automatic logic [2:0] seq_inc(input logic [2:0] v);
      seq_inc = 3'(v + `CSC_SEQ_ONE);
   endfunction : seq_inc

   logic [2:0] c_out_count;
   logic c_out_req;
   logic [2:0] c_in_echo;
   logic c_in_conf;
   logic [7:0] c_byte;

   // split the controller handshake byte into its two nibbles
   assign c_out_count = ctrl_handshake_byte[`CSC_HS_CNT_MSB:`CSC_HS_CNT_LSB];
   assign c_out_req = ctrl_handshake_byte[`CSC_HS_REQ_BIT];
   assign c_in_echo = ctrl_handshake_byte[`CSC_HS_ECHO_MSB:`CSC_HS_ECHO_LSB];
   assign c_in_conf = ctrl_handshake_byte[`CSC_HS_CONF_BIT];
   assign c_byte = st.win[st.wpos[2:0]];

   // next state: the two directions are handled by separate sections
   always_comb begin
      next_st = st;
      next_st.rx_valid = 1'b0;
      next_st.rx_last = 1'b0;
      next_st.rx_drop = 1'b0;

      // output direction, controller to module; independent of input side
      unique case (st.out_st)
         csc_pkg::OS_UNSYNC: begin
            if (cyc_en) begin
               next_st.out_echo = c_out_count;
               next_st.out_confirm = c_out_req;
               if (c_out_count == `CSC_SEQ_ZERO && !c_out_req) begin
                  next_st.out_seen_zero = 1'b1;
               end
               if (st.out_seen_zero && c_out_count == `CSC_SEQ_ONE && !c_out_req) begin
                  next_st.out_confirm = 1'b1;
                  next_st.out_st = csc_pkg::OS_RUN;
               end
            end
         end
         csc_pkg::OS_RUN: begin
            if (cyc_en && (!c_out_req || (!st.walking && c_out_count != st.out_echo
                  && c_out_count != seq_inc(st.out_echo)))) begin
               // request dropped or counter jumped: resync, drop open message
               next_st.out_st = csc_pkg::OS_UNSYNC;
               next_st.out_seen_zero = 1'b0;
               next_st.out_confirm = 1'b0;
               next_st.out_echo = c_out_count;
               next_st.walking = 1'b0;
               next_st.msg_open = 1'b0;
               next_st.rx_drop = st.msg_open;
            end else if (st.walking) begin
               // walk the latched window one byte per clock
               if (st.wpos == st.hdr_pos) begin
                  next_st.seg_left = c_byte[`CSC_HDR_LEN_MSB:`CSC_HDR_LEN_LSB];
                  next_st.seg_final = c_byte[`CSC_HDR_FINAL_BIT];
                  if (c_byte[`CSC_HDR_NEXT_BIT]) begin
                     next_st.hdr_pos = 4'(st.wpos + 4'h1 + c_byte[`CSC_HDR_LEN_MSB:`CSC_HDR_LEN_LSB]);
                  end else begin
                     next_st.hdr_pos = 4'hf; // next header opens the next sequence
                  end
               end else if (st.seg_left != 6'h00) begin
                  next_st.seg_left = 6'(st.seg_left - 6'h01);
                  next_st.rx_data = c_byte;
                  next_st.rx_valid = 1'b1;
                  next_st.msg_open = 1'b1;
                  if (st.seg_left == 6'h01 && st.seg_final) begin
                     next_st.rx_last = 1'b1; // message complete, hand it on
                     next_st.msg_open = 1'b0;
                  end
               end
               if (st.wpos == 4'(`CSC_TX_WIN - 1)) begin
                  next_st.walking = 1'b0;
                  next_st.out_echo = seq_inc(st.out_echo);
               end else begin
                  next_st.wpos = 4'(st.wpos + 4'h1);
               end
            end else if (cyc_en && c_out_count == seq_inc(st.out_echo)) begin
               // new sequence: take the window only now that the channel runs
               next_st.win = tx_window_bytes;
               next_st.walking = 1'b1;
               next_st.wpos = 4'h0;
               next_st.hdr_pos = 4'h0;
               next_st.seg_left = 6'h00;
            end
         end
      endcase

      // input direction, module to controller
      unique case (st.in_st)
         csc_pkg::IS_RESET: begin
            next_st.in_count = `CSC_SEQ_ZERO;
            next_st.in_req = 1'b0;
            next_st.tx_ready = 1'b0;
            if (cyc_en && c_in_echo == `CSC_SEQ_ZERO && !c_in_conf) begin
               next_st.in_count = `CSC_SEQ_ONE;
               next_st.in_st = csc_pkg::IS_STEP;
            end
         end
         csc_pkg::IS_STEP: begin
            if (cyc_en && c_in_echo == `CSC_SEQ_ONE && !c_in_conf) begin
               next_st.in_req = 1'b1;
               next_st.in_st = csc_pkg::IS_REQ;
            end
         end
         csc_pkg::IS_REQ: begin
            if (cyc_en && c_in_conf) begin
               next_st.in_st = csc_pkg::IS_RUN;
            end
         end
         csc_pkg::IS_RUN: begin
            if (cyc_en && !c_in_conf) begin
               // confirm withdrawn: restart sync, abandon the sequence being built
               next_st.in_st = csc_pkg::IS_RESET;
               next_st.in_count = `CSC_SEQ_ZERO;
               next_st.in_req = 1'b0;
               next_st.tx_ready = 1'b0;
            end else if (st.tx_ready) begin
               if (user_tx_valid) begin
                  next_st.rwin[4'(st.tx_len) + 4'h1] = user_tx_data;
                  if (user_tx_last || st.tx_len == 6'(`CSC_RX_WIN - 2)) begin
                     // segment closed: header in byte 0, then publish the sequence
                     next_st.rwin[0] = {user_tx_last, 1'b0, 6'(st.tx_len + 6'h01)};
                     next_st.in_count = seq_inc(st.in_count);
                     next_st.tx_ready = 1'b0;
                  end else begin
                     next_st.tx_len = 6'(st.tx_len + 6'h01);
                  end
               end
            end else if (c_in_echo == st.in_count) begin
               // last sequence acknowledged: stand by or start a new segment
               next_st.rwin[0] = `CSC_IDLE_HEADER;
               if (user_tx_valid) begin
                  next_st.tx_ready = 1'b1;
                  next_st.tx_len = 6'h00;
               end
            end
         end
      endcase
   end

   // state register, synchronous active-low reset
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st <= '0; // unsynced both ways, counters 000, idle header
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign module_handshake_byte = {st.out_confirm, st.out_echo, st.in_req, st.in_count};
   assign rx_window_bytes = st.rwin;
   assign user_rx_data = st.rx_data;
   assign user_rx_valid = st.rx_valid;
   assign user_rx_last = st.rx_last;
   assign user_rx_drop = st.rx_drop;
   assign user_tx_ready = st.tx_ready;
   assign out_synced = (st.out_st == csc_pkg::OS_RUN);
   assign in_synced = (st.in_st == csc_pkg::IS_RUN);
endmodule : csc_channel

// ==== rtl/csc_defines.svh ====
// constants of the cyclic stream channel: byte layouts, window sizes, codes
// assumes one bus exchange per cyc_en pulse; included by bare name
// How it works
// - on interruption drop the unfinished message, keep every completed message
// - output and input channels synchronize and run independently of each other
// - transmit window contents are ignored while the output channel is unsynced
// - during output sync the counter and request are copied into echo and confirm
// - final output sync step: module raises out_link_confirm
// - module starts input sync by loading 000 and clearing in_link_req
// - module waits echo 000 confirm 0, increments, then waits echo 001 confirm 0
// - on echo 001 module raises in_link_req, then waits for confirm 1
// - first header byte sits in byte 0 of the first sequence, one per segment
// - next header position is header position plus one plus chunk_len
// - segment plus header fits one window, chunk_len at most width minus one
// - with nothing pending the transmitter sends an idle header of value 0
// - header: chunk_len bits 0-5, next_header_place bit 6, final_chunk_flag bit 7
// - handshake low nibble: counter and request; high nibble: echo and confirm
// - sender increments its counter after each new sequence; receiver echoes it
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH
`define CSC_TX_WIN 7
`define CSC_RX_WIN 7
`define CSC_HS_CNT_LSB 0
`define CSC_HS_CNT_MSB 2
`define CSC_HS_REQ_BIT 3
`define CSC_HS_ECHO_LSB 4
`define CSC_HS_ECHO_MSB 6
`define CSC_HS_CONF_BIT 7
`define CSC_HDR_LEN_LSB 0
`define CSC_HDR_LEN_MSB 5
`define CSC_HDR_NEXT_BIT 6
`define CSC_HDR_FINAL_BIT 7
`define CSC_IDLE_HEADER 8'h00
`define CSC_SEQ_ZERO 3'h0
`define CSC_SEQ_ONE 3'h1
`endif

// ==== rtl/csc_pkg.sv ====
// types of the cyclic stream channel: sync states and the state record
// assumes csc_defines.svh sets the window widths
`include "csc_defines.svh"
package csc_pkg;
   typedef enum logic [0:0] {OS_UNSYNC, OS_RUN} csc_out_e;
   typedef enum logic [1:0] {IS_RESET, IS_STEP, IS_REQ, IS_RUN} csc_in_e;
   typedef logic [`CSC_TX_WIN-1:0][7:0] csc_txwin_t;
   typedef logic [`CSC_RX_WIN-1:0][7:0] csc_rxwin_t;
   typedef struct packed {
      csc_out_e out_st;
      logic out_seen_zero;
      logic [2:0] out_echo;
      logic out_confirm;
      csc_txwin_t win;
      logic walking;
      logic [3:0] wpos;
      logic [3:0] hdr_pos;
      logic [5:0] seg_left;
      logic seg_final;
      logic msg_open;
      logic [7:0] rx_data;
      logic rx_valid;
      logic rx_last;
      logic rx_drop;
      csc_in_e in_st;
      logic [2:0] in_count;
      logic in_req;
      logic tx_ready;
      logic [5:0] tx_len;
      csc_rxwin_t rwin;
   } csc_state_s;
endpackage : csc_pkg

// ==== testbench/csc_channel_assertions.sv ====
// checker of the cyclic stream channel: handshake nibbles and payload timing
// assumes it is bound to csc_channel and sees its ports only
`timescale 1ns/1ns
module csc_channel_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cyc_en,
   input wire logic [7:0] ctrl_handshake_byte,
   input wire logic [7:0] module_handshake_byte,
   input wire logic user_rx_valid,
   input wire logic out_synced,
   input wire logic in_synced
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire logic [7:0] c = ctrl_handshake_byte;
   wire logic [7:0] m = module_handshake_byte;
   // the two input sync steps as seen at an exchange
   sequence in_zero_s; cyc_en && !in_synced && m[3:0] == 4'h0 && c[7:4] == 4'h0; endsequence
   sequence in_one_s; cyc_en && !in_synced && m[3:0] == 4'h1 && c[7:4] == 4'h1; endsequence
   echo_copy_a: assert property (cyc_en && !out_synced |=> m[6:4] == $past(c[2:0]))
      else $error("output echo not copied");
   conf_rise_a: assert property ($rose(m[7]) |-> m[6:4] == 3'h1 && out_synced)
      else $error("output confirm raised early");
   in_step_a: assert property (in_zero_s |=> m[3:0] == 4'h1)
      else $error("input count not stepped");
   in_req_a: assert property (in_one_s |=> m[3:0] == 4'h9)
      else $error("input request not raised");
   in_done_a: assert property (cyc_en && m[3] && !in_synced && c[7] |=> in_synced)
      else $error("input sync not completed");
   no_payload_a: assert property (!out_synced && !$past(out_synced) |-> !user_rx_valid)
      else $error("payload while unsynced");
   echo_step_a: assert property (out_synced && $past(out_synced) && $changed(m[6:4]) |->
      m[6:4] == $past(m[6:4]) + 3'h1)
      else $error("output echo jumped");
   drop_sync_a: assert property (cyc_en && out_synced && !c[3] |-> ##[1:10] !out_synced)
      else $error("request drop ignored");
endmodule : csc_channel_chk
bind csc_channel csc_channel_chk chk (.*);

// ==== testbench/csc_channel_test.sv ====
// self-checking bench of the cyclic stream channel, both directions
// assumes the controller model paces exchanges and answers the input channel
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module csc_channel_test;
   logic ref_clk = 1'b1;
   logic nrst = 1'b0;
   logic cyc_en, user_rx_valid, user_rx_last, user_rx_drop, user_tx_ready, out_synced, in_synced;
   logic [7:0] ctrl_handshake_byte, module_handshake_byte, user_rx_data;
   logic [7:0] user_tx_data = 8'h00;
   logic user_tx_valid = 1'b0;
   logic user_tx_last = 1'b0;
   logic [3:0] out_low = 4'h0;
   csc_pkg::csc_txwin_t tx_window_bytes = {7{8'h85}};
   csc_pkg::csc_rxwin_t rx_window_bytes, got;
   int err_total = 0;
   int check_count = 0;
   int drops = 0;
   logic [8:0] rxq[$];
   always #50 ref_clk = ~ref_clk;
   csc_channel uut (.*);
   csc_ctrl_model pm (.ref_clk(ref_clk), .nrst(nrst), .out_low(out_low), .mod_hs(module_handshake_byte),
      .rxw(rx_window_bytes), .cyc_en(cyc_en), .ctrl_hs(ctrl_handshake_byte), .got(got));
   // collect payload bytes and drop pulses mid-cycle
   always @(negedge ref_clk) begin
      if (user_rx_valid === 1'b1) rxq.push_back({user_rx_last, user_rx_data});
      if (user_rx_drop === 1'b1) drops++;
   end
   // controller step: new low nibble, then poll the echo
   task send(input logic [3:0] low);
      int i;
      out_low = low;
      repeat (5) @(negedge ref_clk);
      for (i = 0; i < 60 && module_handshake_byte[6:4] !== low[2:0]; i++) @(negedge ref_clk);
   endtask : send
   // offer one message byte until it is taken
   task push(input logic [7:0] d, input logic l);
      int i;
      user_tx_data = d;
      user_tx_last = l;
      user_tx_valid = 1'b1;
      for (i = 0; i < 60 && user_tx_ready !== 1'b1; i++) @(negedge ref_clk);
      @(negedge ref_clk);
   endtask : push
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   // main sequence of tests
   initial begin
      int k;
      repeat (2) @(negedge ref_clk);
      `CHK("reset handshake", 8'h00, module_handshake_byte)
      nrst = 1'b1;
      send(4'h0);
      `CHK("zero echo", 4'h0, module_handshake_byte[7:4])
      send(4'h1);
      `CHK("output confirm", 4'h9, module_handshake_byte[7:4])
      `CHK("unsynced window", 0, rxq.size())
      $display("output sync test done");
      tx_window_bytes = {8'hEE, 8'hEE, 8'hEE, 8'hA2, 8'h81, 8'hA1, 8'hC1};
      send(4'hA);
      `CHK("first byte", 9'h1A1, rxq[0])
      `CHK("last byte", 9'h1A2, rxq[1])
      tx_window_bytes = '0;
      for (k = 3; k < 11; k++) send({1'b1, k[2:0]});
      `CHK("wrapped echo", 4'hA, module_handshake_byte[7:4])
      `CHK("idle delivers none", 2, rxq.size())
      $display("output message test done");
      tx_window_bytes = {8'hEE, 8'hEE, 8'hEE, 8'hEE, 8'hB2, 8'hB1, 8'h02};
      send(4'hB);
      out_low = 4'h3;
      repeat (12) @(negedge ref_clk);
      `CHK("drop pulse", 1, drops)
      `CHK("open byte", 9'h0B2, rxq[3])
      `CHK("output unsynced", 1'b0, out_synced)
      $display("interruption test done");
      for (k = 0; k < 100 && in_synced !== 1'b1; k++) @(negedge ref_clk);
      `CHK("input synced", 1'b1, in_synced)
      push(8'hC1, 1'b0);
      push(8'hC2, 1'b1);
      user_tx_valid = 1'b0;
      for (k = 0; k < 60 && got[0] !== 8'h82; k++) @(negedge ref_clk);
      `CHK("receive window", 24'hC2_C182, got[2:0])
      `CHK("input count", 3'h2, module_handshake_byte[2:0])
      $display("input message test done");
      give_verdict();
   end
   // watchdog: the tests need well under two thousand cycles
   initial begin
      #2000000;
      err_total++;
      give_verdict();
   end
endmodule : csc_channel_test

// ==== testbench/csc_ctrl_model.sv ====
// controller model: paces exchanges and receives on the input channel
// assumes the bench drives the output low nibble and the transmit window
`timescale 1ns/1ns
module csc_ctrl_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [3:0] out_low,
   input wire logic [7:0] mod_hs,
   input wire csc_pkg::csc_rxwin_t rxw,
   output logic cyc_en,
   output logic [7:0] ctrl_hs,
   output csc_pkg::csc_rxwin_t got
);
   logic [1:0] ph;
   logic [3:0] in_hi;
   // high nibble carries input echo and confirm
   assign ctrl_hs = {in_hi, out_low};
   // one exchange every fourth cycle, launched off the falling edge
   always @(negedge ref_clk) begin
      ph <= nrst ? ph + 2'd1 : 2'd0;
      cyc_en <= nrst && ph == 2'd3;
      if (!nrst) begin
         in_hi <= 4'h0;
         got <= '0;
      end else if (ph == 2'd3) begin
         in_hi <= mod_hs[3:0];
         if (mod_hs[3] && in_hi[3] && mod_hs[2:0] != in_hi[2:0]) got <= rxw;
      end
   end
endmodule : csc_ctrl_model
